/* File: core/bpt_pkg.sv */
package bpt_pkg;

   // ====================================================================
   // array geometry and fields
   localparam int NUM_ENTRIES     = 4;
   localparam int IDX_W           = 2;
   localparam int BLOCK_EFF_PAGE_INDEX_W          = 15;
   localparam int BLEN_W          = 11;
   localparam int BLEN_LSB        = 17;
   localparam int PASS_W          = 17;
   localparam int SEG_IDX_MSB     = 31;
   localparam int SEG_IDX_LSB     = 28;
   localparam int PAGE_NUM_MSB    = 27;
   localparam int PAGE_NUM_LSB    = 12;
   localparam int OFFSET_MSB      = 11;
   localparam int VSID_W          = 24;
   localparam int VPN_W           = 40;
   localparam int VA_W            = 52;
   localparam int FAULT_CAUSE_BIT = 4;

   // ====================================================================
   // protection encodings
   localparam logic [1:0] PROT_NONE = 2'h0;
   localparam logic [1:0] PROT_RW   = 2'h2;

   // ====================================================================
   // reset values
   localparam logic [31:0] RST_WORD = 32'h0000_0000;

   typedef enum logic [1:0] {
      BPT_ST_IDLE  = 2'b00,
      BPT_ST_BLOCK = 2'b01,
      BPT_ST_PAGE  = 2'b11,
      BPT_ST_DIRECT= 2'b10
   } bpt_route_t;

   typedef struct packed {
      logic [BLOCK_EFF_PAGE_INDEX_W-1:0] eff_page_index;
      logic [BLEN_W-1:0] length_mask;
      logic              supv_valid_bit;
      logic              user_valid_bit;
   } bpt_upper_t;

   typedef struct packed {
      logic [BLOCK_EFF_PAGE_INDEX_W-1:0] phys_number;
      logic [3:0]        cache_attr_bits;
      logic [1:0]        block_prot_field;
   } bpt_lower_t;

   typedef struct packed {
      logic        valid;
      logic        is_fetch;
      logic        is_write;
      logic        is_touch;
      logic        user_mode;
      logic [31:0] eff_addr;
      logic        seg_type;
      logic [VSID_W-1:0] vsid;
   } bpt_req_t;

   typedef struct packed {
      logic             valid;
      bpt_route_t       route;
      logic [31:0]      phys_addr;
      logic [3:0]       cache_attr_bits;
      logic [VA_W-1:0]  virt_addr;
      logic             data_fault;
      logic             instr_storage_fault;
      logic             nop_abort;
   } bpt_rsp_t;

endpackage

/* File: core/bpt_entry.sv */
`timescale 1ns/100ps
module bpt_entry
   import bpt_pkg::*;
(
   input  wire bpt_pkg::bpt_upper_t upper_i,
   input  wire bpt_pkg::bpt_lower_t lower_i,
   input  wire logic [31:0]         eff_addr_i,
   input  wire logic                user_mode_i,
   output logic                     hit_o,
   output logic [31:0]              phys_addr_o
);
   import bpt_pkg::*;

   logic [BLOCK_EFF_PAGE_INDEX_W-1:0] ea_hi;
   logic [BLOCK_EFF_PAGE_INDEX_W-1:0] mask_ext;
   logic              valid_now;

   always_comb
   begin
      ea_hi     = eff_addr_i[31:BLEN_LSB];
      mask_ext  = {{(BLOCK_EFF_PAGE_INDEX_W-BLEN_W){1'b0}}, upper_i.length_mask};
      valid_now = user_mode_i ? upper_i.user_valid_bit : upper_i.supv_valid_bit;
      hit_o     = valid_now && ((ea_hi & ~mask_ext) == upper_i.eff_page_index);
      // uniform over 128 Kbyte..256 Mbyte
      phys_addr_o = {lower_i.phys_number | (ea_hi & mask_ext),
                     eff_addr_i[PASS_W-1:0]};
   end
endmodule // bpt_entry

/* File: core/bpt_top.sv */
`timescale 1ns/100ps
module bpt_top
   import bpt_pkg::*;
(
   input  wire logic                 ref_clk_i,
   input  wire logic                 rst_n_i,
   input  wire bpt_pkg::bpt_req_t    req_i,
   input  wire logic [3:0]           reg_addr_i,
   input  wire logic [31:0]          reg_wdata_i,
   input  wire logic                 reg_wr_i,
   input  wire logic                 reg_rd_i,
   input  wire logic                 supv_exec_i,
   output bpt_pkg::bpt_rsp_t         rsp_o,
   output logic [31:0]               reg_rdata_o,
   output logic [31:0]               data_fault_cause_reg_o,
   output logic [31:0]               saved_status_reg_o,
   output logic                      wr_refused_o
);
   import bpt_pkg::*;

   // ====================================================================
   // block translation array storage
   // address: bit0 selects lower word, bits 3:1 the entry
   bpt_upper_t        upper_ff [NUM_ENTRIES];
   bpt_lower_t        lower_ff [NUM_ENTRIES];
   logic [NUM_ENTRIES-1:0] hit_vec;
   logic [31:0]       pa_vec [NUM_ENTRIES];
   logic [IDX_W-1:0]  wr_idx;
   logic              addr_ok;

   assign wr_idx  = reg_addr_i[IDX_W:1];
   assign addr_ok = (reg_addr_i[3:1] < 3'(NUM_ENTRIES));

   generate
      for (genvar g = 0; g < NUM_ENTRIES; g++)
      begin : g_ent
         always_ff @(posedge ref_clk_i or negedge rst_n_i)
         begin
            if (!rst_n_i)
            begin
               upper_ff[g] <= bpt_upper_t'(RST_WORD[BLOCK_EFF_PAGE_INDEX_W+BLEN_W+1:0]);
               lower_ff[g] <= bpt_lower_t'(RST_WORD[BLOCK_EFF_PAGE_INDEX_W+5:0]);
            end
            else if (reg_wr_i && supv_exec_i && addr_ok && wr_idx == IDX_W'(g))
            begin
               if (!reg_addr_i[0])
                  upper_ff[g] <= '{reg_wdata_i[31:17], reg_wdata_i[12:2],
                                   reg_wdata_i[1], reg_wdata_i[0]};
               else
                  lower_ff[g] <= '{reg_wdata_i[31:17], reg_wdata_i[6:3],
                                   reg_wdata_i[1:0]};
            end
         end

         bpt_entry u_entry (
            .upper_i     (upper_ff[g]),
            .lower_i     (lower_ff[g]),
            .eff_addr_i  (req_i.eff_addr),
            .user_mode_i (req_i.user_mode),
            .hit_o       (hit_vec[g]),
            .phys_addr_o (pa_vec[g])
         );
      end
   endgenerate

   // ====================================================================
   // register readback and refused-write flag
   always_ff @(posedge ref_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         reg_rdata_o <= RST_WORD;
      else if (reg_rd_i && addr_ok)
      begin
         if (!reg_addr_i[0])
            reg_rdata_o <= {upper_ff[wr_idx].eff_page_index, 4'h0,
                            upper_ff[wr_idx].length_mask,
                            upper_ff[wr_idx].supv_valid_bit,
                            upper_ff[wr_idx].user_valid_bit};
         else
            reg_rdata_o <= {lower_ff[wr_idx].phys_number, 10'h000,
                            lower_ff[wr_idx].cache_attr_bits, 1'b0,
                            lower_ff[wr_idx].block_prot_field};
      end
      else
         reg_rdata_o <= RST_WORD;
   end

   // user-mode write attempt is dropped; pulse lets the core trap it
   always_ff @(posedge ref_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         wr_refused_o <= 1'b0;
      else
         wr_refused_o <= reg_wr_i && !supv_exec_i;
   end

   // ====================================================================
   // hit selection and protection check
   logic [IDX_W-1:0] sel;
   logic             any_hit;
   logic [1:0]       prot;
   logic             violate;
   logic             fault;

   always_comb
   begin
      sel     = '0;
      any_hit = 1'b0;
      // lowest-numbered hit wins; overlapping entries are software error
      for (int i = NUM_ENTRIES-1; i >= 0; i--)
      begin
         if (hit_vec[i])
         begin
            sel     = IDX_W'(i);
            any_hit = 1'b1;
         end
      end
      prot = lower_ff[sel].block_prot_field;
      if (prot == PROT_NONE)
         violate = 1'b1;
      else if (prot[0])
         violate = req_i.is_write;
      else
         violate = 1'b0;
      fault = req_i.valid && any_hit && violate;
   end

   // ====================================================================
   // page path: virtual address and segment kind
   logic [VA_W-1:0] va;
   bpt_route_t      route;

   always_comb
   begin
      // vsid ++ page number ++ offset = 52-bit virtual address
      va = {req_i.vsid, req_i.eff_addr[PAGE_NUM_MSB:0]};
      if (any_hit)
         route = BPT_ST_BLOCK;
      else if (req_i.seg_type)
         route = BPT_ST_DIRECT;
      else
         route = BPT_ST_PAGE;
   end

   // ====================================================================
   // registered answer
   always_ff @(posedge ref_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         rsp_o <= '0;
      else
      begin
         rsp_o.valid <= req_i.valid;
         rsp_o.route <= req_i.valid ? route : BPT_ST_IDLE;
         rsp_o.phys_addr <= (req_i.valid && any_hit && !fault) ? pa_vec[sel] : RST_WORD;
         rsp_o.cache_attr_bits <= (req_i.valid && any_hit) ?
                                  lower_ff[sel].cache_attr_bits : 4'h0;
         rsp_o.virt_addr <= (req_i.valid && route == BPT_ST_PAGE) ? va : '0;
         rsp_o.data_fault <= fault && !req_i.is_fetch && !req_i.is_touch;
         rsp_o.instr_storage_fault <= fault && req_i.is_fetch;
         rsp_o.nop_abort <= fault && !req_i.is_fetch && req_i.is_touch;
      end
   end

   // ====================================================================
   // fault cause bits, set on each data or fetch violation; touch aborts set none
   always_ff @(posedge ref_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         data_fault_cause_reg_o <= RST_WORD;
         saved_status_reg_o     <= RST_WORD;
      end
      else
      begin
         if (fault && !req_i.is_fetch && !req_i.is_touch)
            data_fault_cause_reg_o[FAULT_CAUSE_BIT] <= 1'b1;
         if (fault && req_i.is_fetch)
            saved_status_reg_o[FAULT_CAUSE_BIT] <= 1'b1;
      end
   end
endmodule // bpt_top

/* File: bench/bpt_checker_sva.sv */
`timescale 1ns/100ps
module bpt_checker
   import bpt_pkg::*;
(
   input wire logic             ref_clk_i,
   input wire logic             rst_n_i,
   input wire bpt_pkg::bpt_req_t req_i,
   input wire logic             reg_wr_i,
   input wire logic             supv_exec_i,
   input wire bpt_pkg::bpt_rsp_t rsp_o,
   input wire logic [31:0]      data_fault_cause_reg_o,
   input wire logic [31:0]      saved_status_reg_o,
   input wire logic             wr_refused_o
);
   // ==================================================================
   // sequences
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!rst_n_i);
   sequence s_data_req;
      req_i.valid && !req_i.is_fetch;
   endsequence
   sequence s_touch_req;
      s_data_req ##0 req_i.is_touch;
   endsequence
   // ==================================================================
   // properties
   a_rsp_one_cycle: assert property (req_i.valid |=> rsp_o.valid)
      else $error("response missing");
   a_fault_in_block: assert property (rsp_o.data_fault |->
      rsp_o.route == BPT_ST_BLOCK && rsp_o.phys_addr == 32'h0)
      else $error("fault outside block path");
   a_cause_bit_set: assert property (rsp_o.data_fault |->
      data_fault_cause_reg_o[FAULT_CAUSE_BIT])
      else $error("cause bit not set");
   a_cause_bit_sticky: assert property (data_fault_cause_reg_o[FAULT_CAUSE_BIT] |=>
      data_fault_cause_reg_o[FAULT_CAUSE_BIT])
      else $error("cause bit lost");
   a_fetch_fault_kind: assert property (req_i.valid && req_i.is_fetch |=>
      !rsp_o.data_fault && !rsp_o.nop_abort)
      else $error("fetch gave data fault");
   a_instr_cause_set: assert property (rsp_o.instr_storage_fault |->
      saved_status_reg_o[FAULT_CAUSE_BIT])
      else $error("status bit not set");
   a_touch_silent: assert property (s_touch_req |=>
      !rsp_o.data_fault && !rsp_o.instr_storage_fault)
      else $error("touch raised fault");
   a_write_refused: assert property (reg_wr_i && !supv_exec_i |=> wr_refused_o)
      else $error("user write not refused");
   a_low_bits_pass: assert property (rsp_o.valid && rsp_o.route == BPT_ST_BLOCK
      && !rsp_o.data_fault && !rsp_o.instr_storage_fault && !rsp_o.nop_abort
      |-> rsp_o.phys_addr[16:0] == $past(req_i.eff_addr[16:0]))
      else $error("low address bits altered");
   a_direct_bypass: assert property (rsp_o.route == BPT_ST_DIRECT |->
      rsp_o.virt_addr == '0)
      else $error("direct segment paged");
endmodule // bpt_checker

bind bpt_top bpt_checker u_chk (.ref_clk_i, .rst_n_i, .req_i, .reg_wr_i, .supv_exec_i,
   .rsp_o, .data_fault_cause_reg_o, .saved_status_reg_o, .wr_refused_o);

/* File: bench/bpt_core_model.sv */
`timescale 1ns/100ps
module bpt_core_model
   import bpt_pkg::*;
(
   input  wire logic        ref_clk_i,
   output bpt_pkg::bpt_req_t req_o
);
   // arbitrary segment id
   localparam logic [VSID_W-1:0] VSID_V = 24'h5A3C1E;
   initial req_o = '0;
   // ==================================================================
   // one request, then released fields inverted so stale values never match
   task automatic issue(input logic f, w, t, u, s, input logic [31:0] ea);
      bpt_req_t nxt;
      @(posedge ref_clk_i);
      req_o <= '{1'b1, f, w, t, u, ea, s, VSID_V};
      @(posedge ref_clk_i);
      nxt = ~req_o;
      nxt.valid = 1'b0;
      req_o <= nxt;
      #1;
   endtask
endmodule // bpt_core_model

/* File: bench/block_protect_translate_tb.sv */
`timescale 1ns/100ps
module block_protect_translate_tb;
   import bpt_pkg::*;
   logic        ref_clk_i = 1'b0;
   logic        rst_n_i   = 1'b0;
   logic [3:0]  ra        = 4'h0;
   logic [31:0] wd        = 32'h0;
   logic        wr        = 1'b0;
   logic        rdstb     = 1'b0;
   logic        sx        = 1'b1;
   logic [31:0] rd, dfc, ssr, v;
   logic        refu, flt;
   bpt_req_t    req;
   bpt_rsp_t    rsp;
   int          n_errors = 0;
   int          n_compared = 0;
   int          cyc = 0;
   always #4 ref_clk_i = ~ref_clk_i;
   bpt_core_model core (.ref_clk_i, .req_o(req));
   bpt_top dut (.ref_clk_i, .rst_n_i, .req_i(req), .reg_addr_i(ra), .reg_wdata_i(wd),
      .reg_wr_i(wr), .reg_rd_i(rdstb), .supv_exec_i(sx), .rsp_o(rsp), .reg_rdata_o(rd),
      .data_fault_cause_reg_o(dfc), .saved_status_reg_o(ssr), .wr_refused_o(refu));
   // ==================================================================
   // helpers
   task automatic chk(input logic [63:0] seen, exp);
      n_compared++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("unexpected at %0t: %h vs %h", $time, seen, exp);
      end
   endtask
   task automatic wreg(input logic [3:0] a, input logic [31:0] d);
      @(posedge ref_clk_i);
      ra <= a;
      wd <= d;
      wr <= 1'b1;
      @(posedge ref_clk_i);
      wr <= 1'b0;
      #1;
   endtask
   task automatic rreg(input logic [3:0] a, output logic [31:0] d);
      @(posedge ref_clk_i);
      ra <= a;
      rdstb <= 1'b1;
      @(posedge ref_clk_i);
      rdstb <= 1'b0;
      #1 d = rd;
   endtask
   task automatic give_verdict();
      $display("compared %0d errors %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   // hang guard, tests take well under a thousand cycles
   always @(posedge ref_clk_i)
   begin
      cyc++;
      if (cyc == 2000)
      begin
         n_errors++;
         give_verdict();
      end
   end
   // ==================================================================
   // tests
   initial
   begin
      repeat (10) @(posedge ref_clk_i);
      rst_n_i <= 1'b1;
      #1 chk(rsp.valid, 0);
      chk(dfc, 0);
      wreg(4'h0, 32'h0002_0002); // entry 0: 128K at 0x0002_0000, supervisor only
      rreg(4'h0, v);
      chk(v, 32'h0002_0002);
      rreg(4'hA, v);
      chk(v, 0);
      for (int p = 0; p < 4; p++)
         for (int w = 0; w < 2; w++)
         begin
            wreg(4'h1, 32'h0020_0050 | p);
            core.issue(0, w[0], 0, 0, 0, 32'h0003_1234);
            flt = (p == 0) || (p[0] && w[0]);
            chk(rsp.data_fault, flt);
            chk(rsp.phys_addr, flt ? 32'h0 : 32'h0021_1234);
            chk(rsp.cache_attr_bits, 4'hA);
            chk(rsp.route, BPT_ST_BLOCK);
         end
      chk(dfc[FAULT_CAUSE_BIT], 1);
      wreg(4'h2, 32'h7000_1FFE); // entry 1: 256M block
      wreg(4'h3, 32'h9000_0002);
      core.issue(0, 1, 0, 0, 0, 32'h7ABC_DEF0);
      chk(rsp.phys_addr, 32'h9ABC_DEF0);
      // answer stands one cycle only, then drops with no request
      @(posedge ref_clk_i);
      #1 chk(rsp.valid, 0);
      chk(rsp.phys_addr, 0);
      // lower word readback: number, attributes, protection
      rreg(4'h3, v);
      chk(v, 32'h9000_0002);
      @(posedge ref_clk_i);
      #1 chk(rd, 0);
      wreg(4'h1, 32'h0020_0050);
      core.issue(1, 0, 0, 0, 0, 32'h0003_1234);
      chk(rsp.instr_storage_fault, 1);
      chk(ssr[FAULT_CAUSE_BIT], 1);
      core.issue(0, 1, 1, 0, 0, 32'h0003_1234);
      chk({rsp.nop_abort, rsp.data_fault}, 2'h2);
      core.issue(0, 0, 0, 1, 0, 32'h0003_1234);
      chk(rsp.route, BPT_ST_PAGE);
      chk(rsp.virt_addr, {24'h5A3C1E, 28'h003_1234});
      core.issue(0, 0, 0, 1, 1, 32'h0003_1234);
      chk(rsp.route, BPT_ST_DIRECT);
      @(posedge ref_clk_i) sx <= 1'b0;
      wreg(4'h0, 32'h0002_0001);
      chk(refu, 1);
      rreg(4'h0, v);
      chk(v, 32'h0002_0002);
      @(posedge ref_clk_i) sx <= 1'b1;
      // supervisor write lands: entry 0 now user-only
      wreg(4'h0, 32'h0002_0001);
      chk(refu, 0);
      rreg(4'h0, v);
      chk(v, 32'h0002_0001);
      core.issue(0, 0, 0, 1, 0, 32'h0003_1234);
      chk(rsp.route, BPT_ST_BLOCK);
      chk(rsp.data_fault, 1);
      core.issue(0, 0, 0, 0, 0, 32'h0003_1234);
      chk(rsp.route, BPT_ST_PAGE);
      chk(rsp.data_fault, 0);
      // mid-run reset clears cause bits and invalidates entries
      @(posedge ref_clk_i) rst_n_i <= 1'b0;
      repeat (2) @(posedge ref_clk_i);
      rst_n_i <= 1'b1;
      #1 chk(dfc, 0);
      chk(ssr, 0);
      rreg(4'h0, v);
      chk(v, 0);
      core.issue(0, 0, 0, 0, 0, 32'h0003_1234);
      chk(rsp.route, BPT_ST_PAGE);
      give_verdict();
   end
endmodule // block_protect_translate_tb
